// ### design/plss_top.v
// PHY control register and read-only PHY status register
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "plss_defs.vh"
module plss_top
(
	input  wire                    clock_in,
	input  wire                    sys_rst_in,
	input  wire [`PLSS_ADDR_W-1:0] addr_in,
	input  wire [`PLSS_DATA_W-1:0] wdata_in,
	input  wire                    wr_in,
	input  wire                    rd_in,
	input  wire                    link_up_in,
	input  wire                    link_half_in,
	input  wire                    link_10m_in,
	output wire [`PLSS_DATA_W-1:0] rdata_out,
	output wire [2:0]              phy_control_reg_out
);

////////////////////////////////////////////////////////////////////////////////
// Plain equality in one place, so write and read decode agree
function addr_hit;
	input [`PLSS_ADDR_W-1:0] addr;
	input [`PLSS_ADDR_W-1:0] target;
	begin
		addr_hit = (addr == target);
	end
endfunction

// Unused status bits keep their reset value
function [`PLSS_DATA_W-1:0] status_pack;
	input [`PLSS_DATA_W-1:0] ctrl;
	input                    duplex_flag;
	input                    speed_flag;
	begin
		status_pack = `PLSS_STAT_RST;
		status_pack[`PLSS_STAT_AUTO_BIT] =
			ctrl[`PLSS_CTRL_AUTO_BIT];
		status_pack[`PLSS_STAT_CFG_10M_BIT] =
			ctrl[`PLSS_CTRL_10M_BIT];
		status_pack[`PLSS_STAT_CFG_HALF_BIT] =
			ctrl[`PLSS_CTRL_HALF_BIT];
		status_pack[`PLSS_STAT_LINK_HALF_BIT] =
			duplex_flag;
		status_pack[`PLSS_STAT_LINK_10M_BIT] =
			speed_flag;
	end
endfunction

// Read source select codes
localparam RD_NONE = 2'h0;
localparam RD_CTRL = 2'h1;
localparam RD_STAT = 2'h2;

////////////////////////////////////////////////////////////////////////////////
wire [2:0]              link_sync;
wire                    link_up_sync;
wire                    link_half_sync;
wire                    link_10m_sync;
wire                    wr_ctrl;
wire                    rd_ctrl;
wire                    rd_stat;
reg  [1:0]              rd_sel;
reg  [`PLSS_DATA_W-1:0] phy_control_reg_ff;
reg  [`PLSS_DATA_W-1:0] nxt_phy_control_reg;
reg                     link_duplex_flag_ff;
reg                     nxt_link_duplex_flag;
reg                     link_speed_flag_ff;
reg                     nxt_link_speed_flag;
reg  [`PLSS_DATA_W-1:0] status_ff;
reg  [`PLSS_DATA_W-1:0] nxt_status;
reg  [`PLSS_DATA_W-1:0] rdata_ff;
reg  [`PLSS_DATA_W-1:0] nxt_rdata;

// Pins come from the PHY analog side, not this clock
plss_sync u_sync
(
	.clock_in   (clock_in),
	.sys_rst_in (sys_rst_in),
	.async_in   ({link_up_in, link_half_in, link_10m_in}),
	.sync_out   (link_sync)
);

assign link_up_sync   = link_sync[2];
assign link_half_sync = link_sync[1];
assign link_10m_sync  = link_sync[0];

////////////////////////////////////////////////////////////////////////////////
// Any other address decodes to nothing, so status writes are lost
assign wr_ctrl = wr_in && addr_hit(addr_in, `PLSS_ADDR_CTRL);
assign rd_ctrl = rd_in && addr_hit(addr_in, `PLSS_ADDR_CTRL);
assign rd_stat = rd_in && addr_hit(addr_in, `PLSS_ADDR_STAT);

////////////////////////////////////////////////////////////////////////////////
// Only the low three bits exist; the rest always read 0
always @*
begin
	nxt_phy_control_reg = phy_control_reg_ff;
	if (wr_ctrl)
	begin
		nxt_phy_control_reg = wdata_in & `PLSS_CTRL_MASK;
	end
end

always @(posedge clock_in)
begin
	if (sys_rst_in)
	begin
		phy_control_reg_ff <= `PLSS_CTRL_RST;
	end
	else
	begin
		phy_control_reg_ff <= nxt_phy_control_reg;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Flags hold their last value while the link is down, so a read
// after a drop still tells what the link last ran at
always @*
begin
	nxt_link_duplex_flag = link_duplex_flag_ff;
	if (link_up_sync)
	begin
		nxt_link_duplex_flag = link_half_sync;
	end
end

always @(posedge clock_in)
begin
	if (sys_rst_in)
	begin
		link_duplex_flag_ff <= 1'b0;
	end
	else
	begin
		link_duplex_flag_ff <= nxt_link_duplex_flag;
	end
end

always @*
begin
	nxt_link_speed_flag = link_speed_flag_ff;
	if (link_up_sync)
	begin
		nxt_link_speed_flag = link_10m_sync;
	end
end

always @(posedge clock_in)
begin
	if (sys_rst_in)
	begin
		link_speed_flag_ff <= 1'b0;
	end
	else
	begin
		link_speed_flag_ff <= nxt_link_speed_flag;
	end
end

////////////////////////////////////////////////////////////////////////////////
always @*
begin
	nxt_status = status_pack(phy_control_reg_ff, link_duplex_flag_ff,
		link_speed_flag_ff);
end

// No write path reaches the status register except through the control bits copied into bits 5:3
always @(posedge clock_in)
begin
	if (sys_rst_in)
	begin
		status_ff <= `PLSS_STAT_RST;
	end
	else
	begin
		status_ff <= nxt_status;
	end
end

////////////////////////////////////////////////////////////////////////////////
always @*
begin
	rd_sel = RD_NONE;
	if (rd_ctrl)
	begin
		rd_sel = RD_CTRL;
	end
	else if (rd_stat)
	begin
		rd_sel = RD_STAT;
	end
end

// Read data is zero outside the one cycle after a read strobe
always @*
begin
	case (rd_sel)
		RD_CTRL:
		begin
			nxt_rdata = phy_control_reg_ff;
		end
		RD_STAT:
		begin
			nxt_rdata = status_ff;
		end
		default:
		begin
			nxt_rdata = {`PLSS_DATA_W{1'b0}};
		end
	endcase
end

always @(posedge clock_in)
begin
	if (sys_rst_in)
	begin
		rdata_ff <= {`PLSS_DATA_W{1'b0}};
	end
	else
	begin
		rdata_ff <= nxt_rdata;
	end
end

////////////////////////////////////////////////////////////////////////////////
assign rdata_out           = rdata_ff;
assign phy_control_reg_out = phy_control_reg_ff[2:0];

endmodule // plss_top

// ### design/plss_defs.vh
// Constants for the PHY link status bits block
//
// Function
// - Status bit 5 reads 1 when auto-negotiation disabled, 0 when enabled.
// - Auto-negotiation status bit copies PHY control register bit 2.
// - Status bit 4 copies control bit 1; 1 means 10Mbps, 0 100Mbps.
// - Status bit 3 copies control bit 0; 1 half duplex, 0 full.
// - While link up, status bit 2 shows actual duplex, 1 half.
// - While link up, status bit 1 shows actual speed, 1 10Mbps.
`ifndef PLSS_DEFS_VH
`define PLSS_DEFS_VH

`define PLSS_ADDR_W          4
`define PLSS_DATA_W          8
`define PLSS_ADDR_CTRL       4'h0
`define PLSS_ADDR_STAT       4'h1
`define PLSS_CTRL_RST        8'h00
`define PLSS_STAT_RST        8'h00
`define PLSS_CTRL_HALF_BIT      0
`define PLSS_CTRL_10M_BIT       1
`define PLSS_CTRL_AUTO_BIT      2
`define PLSS_STAT_LINK_10M_BIT  1
`define PLSS_STAT_LINK_HALF_BIT 2
`define PLSS_STAT_CFG_HALF_BIT  3
`define PLSS_STAT_CFG_10M_BIT   4
`define PLSS_STAT_AUTO_BIT      5
`define PLSS_CTRL_MASK       8'h07

`endif

// ### design/plss_sync.v
// Two-flop synchroniser for the pin-level link inputs
`timescale 1ns/10ps
module plss_sync
(
	input  wire       clock_in,
	input  wire       sys_rst_in,
	input  wire [2:0] async_in,
	output wire [2:0] sync_out
);

reg [2:0] meta_ff;
reg [2:0] sync_ff;

always @(posedge clock_in)
begin
	if (sys_rst_in)
	begin
		meta_ff <= 3'h0;
		sync_ff <= 3'h0;
	end
	else
	begin
		meta_ff <= async_in;
		sync_ff <= meta_ff;
	end
end

assign sync_out = sync_ff;

endmodule // plss_sync

// ### bench/plss_sva.sv
// Port assertions for the PHY status block
`timescale 1ns/10ps
module plss_sva
(
	input wire       clock_in,
	input wire       sys_rst_in,
	input wire [3:0] addr_in,
	input wire [7:0] wdata_in,
	input wire       wr_in,
	input wire       rd_in,
	input wire       link_up_in,
	input wire       link_half_in,
	input wire       link_10m_in,
	input wire [7:0] rdata_out,
	input wire [2:0] phy_control_reg_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_up;
		(link_up_in && link_half_in && link_10m_in) [*6];
	endsequence
	sequence s_steady;
		(link_up_in && $stable(link_half_in) && $stable(link_10m_in)) [*6];
	endsequence
	sequence s_rd_stat;
		rd_in && addr_in == 4'h1;
	endsequence
	AST_CTL: assert property (wr_in && addr_in == 4'h0 |=>
		phy_control_reg_out == $past(wdata_in[2:0])) else $error("ctl");
	AST_RO: assert property (wr_in && addr_in != 4'h0 |=>
		$stable(phy_control_reg_out)) else $error("ro");
	AST_CFG: assert property (s_rd_stat ##0 !$past(wr_in) |=>
		rdata_out[5:3] == $past(phy_control_reg_out)) else $error("cfg");
	AST_FLG: assert property (s_up ##0 s_rd_stat |=>
		rdata_out[2:1] == 2'h3) else $error("flag");
	AST_LNK: assert property (s_steady ##0 s_rd_stat |=>
		rdata_out[2:1] == $past({link_half_in, link_10m_in}))
		else $error("link");
	AST_RDC: assert property (rd_in && addr_in == 4'h0 |=>
		rdata_out == {5'h00, $past(phy_control_reg_out)})
		else $error("rdc");
	AST_RDZ: assert property (rd_in && addr_in > 4'h1 |=>
		rdata_out == 8'h00) else $error("rdz");
	AST_RSV: assert property (s_rd_stat |=>
		rdata_out[7:6] == 2'h0 && !rdata_out[0]) else $error("rsv");
endmodule // plss_sva

// ### bench/plss_phy.sv
// PHY pin model for the link state inputs
`timescale 1ns/10ps
module plss_phy
(
	input  wire [2:0] state_in,
	output wire [2:0] pins_out
);
	// Pins move a little after the bench asks, off any clock edge
	assign #7 pins_out = state_in;
endmodule // plss_phy

// ### bench/tb.sv
// PHY status block bench
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
	n_mismatch++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
	reg        clock_in = 1'h0, sys_rst_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0;
	reg  [3:0] addr_in = 4'h0;
	reg  [7:0] wdata_in = 8'h00;
	reg  [2:0] phy_state = 3'h7;
	wire [7:0] rdata_out;
	wire [2:0] phy_control_reg_out, p;
	int        n_mismatch = 0, cmp_count = 0, i;
	plss_phy plss_phy_i (.state_in(phy_state), .pins_out(p));
	plss_top plss_top_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.link_up_in(p[2]), .link_half_in(p[1]), .link_10m_in(p[0]),
		.rdata_out(rdata_out), .phy_control_reg_out(phy_control_reg_out));
	task acc(input w, input [3:0] a, input [7:0] d);
		@(posedge clock_in);
		{wr_in, rd_in, addr_in, wdata_in} <= {w, !w, a, d};
		@(posedge clock_in);
		{wr_in, rd_in} <= 2'h0;
		#1 if (!w) `CHK("rdata", d, rdata_out)
	endtask
	// Pins need two sync stages, a flag and a status stage to show
	task link(input [2:0] s, input [7:0] d);
		@(posedge clock_in);
		phy_state <= s;
		repeat (5) @(posedge clock_in);
		acc(1'h0, 4'h1, d);
	endtask
	task give_verdict(input int bad);
		n_mismatch += bad;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial forever #50 clock_in = ~clock_in;
	initial #100000 give_verdict(1);
	initial
	begin
		repeat (12) @(posedge clock_in);
		sys_rst_in <= 1'h0;
		acc(1'h0, 4'h9, 8'h00);
		for (i = 0; i < 8; i++)
		begin
			acc(1'h1, 4'h0, 8'hf8 | i[7:0]);
			`CHK("control", i[2:0], phy_control_reg_out)
			acc(1'h0, 4'h0, {5'h00, i[2:0]});
			acc(1'h0, 4'h1, {2'h0, i[2:0], 3'h6});
		end
		acc(1'h1, 4'h1, 8'h00);
		`CHK("control", 3'h7, phy_control_reg_out)
		acc(1'h0, 4'h1, 8'h3e);
		link(3'h4, 8'h38);
		link(3'h3, 8'h38);
		link(3'h6, 8'h3c);
		link(3'h5, 8'h3a);
		@(posedge clock_in);
		sys_rst_in <= 1'h1;
		repeat (2) @(posedge clock_in);
		sys_rst_in <= 1'h0;
		#1 `CHK("control", 3'h0, phy_control_reg_out)
		acc(1'h0, 4'h0, 8'h00);
		give_verdict(0);
	end
endmodule // tb
bind plss_top plss_sva plss_sva_i (.clock_in(clock_in),
	.sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .link_up_in(link_up_in),
	.link_half_in(link_half_in), .link_10m_in(link_10m_in),
	.rdata_out(rdata_out), .phy_control_reg_out(phy_control_reg_out));
